/* File: pfh_pkg.sv */
/*
  Package for the parallel flash host controller: pin widths, command
  addresses and data, and bus timing counts.
  Assumes a 25 MHz system clock.
*/
package pfh_pkg;
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned ADDR_W         = 17;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned ARRAY_DEPTH    = 131072;
  localparam logic [16:0] CMD_ADDR_1     = 17'h05555;
  localparam logic [16:0] CMD_ADDR_2     = 17'h02AAA;
  localparam logic [7:0]  CMD_DATA_AA    = 8'hAA;
  localparam logic [7:0]  CMD_DATA_55    = 8'h55;
  localparam logic [7:0]  CMD_DATA_80    = 8'h80;
  localparam logic [7:0]  CMD_DATA_A0    = 8'hA0;
  localparam logic [7:0]  CMD_DATA_CHIP  = 8'h10;
  localparam logic [7:0]  CMD_DATA_LOCK  = 8'h40;
  localparam logic [7:0]  CMD_DATA_ID    = 8'h90;
  localparam logic [7:0]  CMD_DATA_IDX   = 8'hF0;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam int unsigned TOGGLE_BIT     = 6;
  localparam int unsigned POLL_BIT       = 7;
  localparam int unsigned LOCK_BIT       = 0;
  localparam logic [16:0] LOCK_DET_BOT   = 17'h00002;
  localparam logic [16:0] LOCK_DET_TOP   = 17'h1C002;
  // Bus phase lengths in ns; counts round up so each minimum is kept.
  localparam int unsigned T_SETUP_NS     = 40;
  localparam int unsigned T_PULSE_NS     = 80;
  localparam int unsigned T_ACCESS_NS    = 120;
  localparam int unsigned T_SETUP_CYC    = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_PULSE_CYC    = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_ACCESS_CYC   = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_RESET_NS     = 500;
  localparam int unsigned T_RESET_CYC    = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W          = 8;

  typedef enum logic [2:0] {
    PFH_OP_READ,
    PFH_OP_PROGRAM,
    PFH_OP_CHIP_ERASE,
    PFH_OP_LOCKOUT,
    PFH_OP_ID_ENTRY,
    PFH_OP_ID_EXIT,
    PFH_OP_RESET
  } pfh_op_t;
endpackage : pfh_pkg

/* File: pfh_cyc_if.sv */
/*
  Carrier between the sequencer and the bus cycle engine.
  Assumes both ends sit on clk_sys.
*/
`timescale 1ns/10ps
interface pfh_cyc_if;
  import pfh_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : pfh_cyc_if

/* File: pfh_cycle.sv */
/*
  Bus cycle engine: one read or one write cycle on the flash pins.
  Assumes data_pins input arrives asynchronously and is synchronised here.
*/
`timescale 1ns/10ps
module pfh_cycle
  import pfh_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  pfh_cyc_if.eng                 cyc,
  output logic [ADDR_W-1:0]      addr_pins,
  output logic [DATA_W-1:0]      data_pins_o,
  output logic                   data_pins_oe,
  input  wire logic [DATA_W-1:0] data_pins_i,
  output logic                   cs_n,
  output logic                   oe_n,
  output logic                   we_n
);
  typedef enum logic [2:0] {PFC_IDLE, PFC_SETUP, PFC_PULSE, PFC_HOLD, PFC_DONE} pfc_state_t;

  pfc_state_t        state_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [DATA_W-1:0] sync1_r;
  logic [DATA_W-1:0] sync2_r;
  logic [DATA_W-1:0] rdata_r;
  logic              wr_r;

  initial assert (T_ACCESS_CYC + 2 < 256 && T_PULSE_CYC > 0) else $error("Bad timing counts.");

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end
    else
    begin
      sync1_r <= data_pins_i;
      sync2_r <= sync1_r;
    end
  end

  // Address is set while both strobes are high, so the device latches it at
  // the single falling edge of we_n, which is the later edge. see R6
  // Output gate stays high through writes. see R5
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r     <= PFC_IDLE;
      cnt_r       <= 8'h00;
      addr_pins   <= 17'h00000;
      data_pins_o <= 8'h00;
      data_pins_oe <= 1'b0;
      cs_n        <= 1'b1;
      oe_n        <= 1'b1;
      we_n        <= 1'b1;
      wr_r        <= 1'b0;
      rdata_r     <= 8'h00;
    end
    else
    begin
      unique case (state_r)
        PFC_IDLE:
        begin
          if (cyc.req)
          begin
            addr_pins    <= cyc.addr;
            data_pins_o  <= cyc.wdata;
            data_pins_oe <= cyc.wr;
            wr_r         <= cyc.wr;
            cs_n         <= 1'b0;
            cnt_r        <= CNT_W'(T_SETUP_CYC);
            state_r      <= PFC_SETUP;
          end
        end
        PFC_SETUP:
        begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01)
          begin
            we_n    <= !wr_r;
            oe_n    <= wr_r;
            cnt_r   <= wr_r ? CNT_W'(T_PULSE_CYC) : CNT_W'(T_ACCESS_CYC + 2);
            state_r <= PFC_PULSE;
          end
        end
        PFC_PULSE:
        begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01)
          begin
            // Rising we_n comes before cs_n, so data is taken here. see R7
            we_n    <= 1'b1;
            oe_n    <= 1'b1;
            rdata_r <= sync2_r;
            state_r <= PFC_HOLD;
          end
        end
        PFC_HOLD:
        begin
          cs_n         <= 1'b1;
          data_pins_oe <= 1'b0;
          state_r      <= PFC_DONE;
        end
        PFC_DONE:
        begin
          state_r <= PFC_IDLE;
        end
        default:
        begin
          state_r <= PFC_IDLE;
        end
      endcase
    end
  end

  assign cyc.done  = (state_r == PFC_DONE);
  assign cyc.rdata = rdata_r;
endmodule : pfh_cycle

/* File: pfh_host.sv */
/*
  Host controller for a byte-wide parallel flash: issues reads, command
  sequences, erase and program, and polls the toggle bit until done or a POLL_LIMIT timeout.
  Assumes the flash pins connect directly; the testbench resolves the data wire.
*/
`timescale 1ns/10ps
// Notes on behaviour
// R1: Flash holds 131072 bytes on 17 address and 8 data pins.
// R2: Reads drive cs and oe low with we high, then sample data.
// R3: Host releases data pins whenever it is not writing.
// R4: Device powers up in read or standby; host starts idle.
// R5: Writes pulse we low under cs low with oe held high.
// R6: Address is latched at the later falling strobe edge.
// R7: Data is latched at the earlier rising strobe edge.
// R8: Command cycles do not change stored array bytes.
// R9: Low reset pin aborts device work and floats its outputs.
// R10: After a reset during program or erase, host must reissue it.
// R11: Device returns to read or standby when reset rises.
// R12: High-voltage reset level lets boot block be reprogrammed.
// R13: Erased bytes read ones; erase before reprogramming.
// R14: Chip erase is six command writes to set addresses and data.
// R15: Chip erase is internally timed within a maximum time.
// R16: Lockout keeps boot block through chip erase.
// R17: Device returns to read mode after chip erase.
// R18: Device ignores commands during chip erase.
// R19: A command sequence enables boot block lockout.
// R20: Lockout is permanent or overridable by high reset level.
// R21: Bottom-boot map places boot block at 00000-03FFF.
// R22: Top-boot map places boot block at 1C000-1FFFF.
// R23: Toggle bit inverts on successive reads while busy.
// R24: Poll bit reads complemented while a byte program runs.
// R25: Lockout-detect location reads bit 0 set when locked.
// R26: Mismatched command cycles abandon a sequence to read mode.
// R27: Device reports busy through status reads until done.
module pfh_host
  import pfh_pkg::*;
#(
  parameter bit          TOP_BOOT       = 1'b0,
  parameter int unsigned POLL_LIMIT     = 1000000
)
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       op_valid,
  output logic                            op_ready,
  input  wire pfh_pkg::pfh_op_t           op_code,
  input  wire logic [pfh_pkg::ADDR_W-1:0] op_addr,
  input  wire logic [pfh_pkg::DATA_W-1:0] op_wdata,
  output logic                            rsp_valid,
  output logic [pfh_pkg::DATA_W-1:0]      rsp_rdata,
  output logic                            rsp_timeout,
  output logic                            rsp_locked,
  input  wire logic                       boost_req,
  output logic [pfh_pkg::ADDR_W-1:0]      address_pins,
  output logic [pfh_pkg::DATA_W-1:0]      data_pins_o,
  output logic                            data_pins_oe,
  input  wire logic [pfh_pkg::DATA_W-1:0] data_pins_i,
  output logic                            cs_n,
  output logic                            oe_n,
  output logic                            we_n,
  output logic                            flash_rst_n,
  output logic                            boost_en
);
  import pfh_pkg::*;

  typedef enum logic [2:0] {PFH_IDLE, PFH_CMD, PFH_ACCESS, PFH_POLL, PFH_RESP, PFH_RESET} pfh_state_t;

  pfh_cyc_if cyc ();

  pfh_state_t        state_r;
  pfh_op_t           op_r;
  logic [2:0]        step_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] prev_r;
  logic              have_prev_r;
  logic [31:0]       poll_cnt_r;
  logic [CNT_W-1:0]  rst_cnt_r;
  logic              req_r;
  logic              wr_r;
  logic [ADDR_W-1:0] caddr_r;
  logic [DATA_W-1:0] cdata_r;

  initial assert (ADDR_W == 17 && DATA_W == 8 && POLL_LIMIT > 0) else $error("Unsupported parameters.");

  // Unlock prefix and final data of each command sequence. see R14 see R19
  function automatic logic [2:0] seq_len(input pfh_op_t op);
    unique case (op)
      PFH_OP_CHIP_ERASE, PFH_OP_LOCKOUT: seq_len = 3'd6;
      PFH_OP_PROGRAM:                    seq_len = 3'd4;
      PFH_OP_ID_ENTRY, PFH_OP_ID_EXIT:   seq_len = 3'd3;
      default:                           seq_len = 3'd0;
    endcase
  endfunction : seq_len

  function automatic logic [DATA_W-1:0] last_data(input pfh_op_t op, input logic [DATA_W-1:0] d);
    unique case (op)
      PFH_OP_CHIP_ERASE: last_data = CMD_DATA_CHIP;
      PFH_OP_LOCKOUT:    last_data = CMD_DATA_LOCK;
      PFH_OP_ID_ENTRY:   last_data = CMD_DATA_ID;
      PFH_OP_ID_EXIT:    last_data = CMD_DATA_IDX;
      default:           last_data = d;
    endcase
  endfunction : last_data

  always_comb
  begin
    caddr_r = CMD_ADDR_1;
    cdata_r = CMD_DATA_AA;
    unique case (step_r)
      3'd0, 3'd3:
      begin
        caddr_r = CMD_ADDR_1;
        cdata_r = CMD_DATA_AA;
      end
      3'd1, 3'd4:
      begin
        caddr_r = CMD_ADDR_2;
        cdata_r = CMD_DATA_55;
      end
      default:
      begin
        caddr_r = CMD_ADDR_1;
        cdata_r = (op_r == PFH_OP_PROGRAM) ? CMD_DATA_A0 : CMD_DATA_80;
      end
    endcase
    // Last cycle of program goes to the target byte. see R8
    if (step_r == seq_len(op_r) - 3'd1)
    begin
      cdata_r = last_data(op_r, wdata_r);
      if (op_r == PFH_OP_PROGRAM)
        caddr_r = addr_r;
    end
  end

  assign cyc.req   = req_r;
  assign cyc.wr    = wr_r;
  assign cyc.addr  = (state_r == PFH_CMD) ? caddr_r : addr_r;
  assign cyc.wdata = cdata_r;
  assign op_ready  = (state_r == PFH_IDLE);

  // The high-voltage enable is held only while boot-block work is wanted. see R12 see R20
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      boost_en <= 1'b0;
    else
      boost_en <= boost_req && flash_rst_n;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r     <= PFH_IDLE;
      op_r        <= PFH_OP_READ;
      step_r      <= 3'd0;
      addr_r      <= 17'h00000;
      wdata_r     <= 8'h00;
      prev_r      <= 8'h00;
      have_prev_r <= 1'b0;
      poll_cnt_r  <= 32'h00000000;
      rst_cnt_r   <= 8'h00;
      req_r       <= 1'b0;
      wr_r        <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_rdata   <= 8'h00;
      rsp_timeout <= 1'b0;
      rsp_locked  <= 1'b0;
      flash_rst_n <= 1'b1; // see R4
    end
    else
    begin
      req_r     <= 1'b0;
      rsp_valid <= 1'b0;
      unique case (state_r)
        PFH_IDLE:
        begin
          if (op_valid)
          begin
            op_r        <= op_code;
            addr_r      <= op_addr;
            wdata_r     <= op_wdata;
            step_r      <= 3'd0;
            have_prev_r <= 1'b0;
            poll_cnt_r  <= 32'h00000000;
            rsp_timeout <= 1'b0;
            if (op_code == PFH_OP_RESET)
            begin
              // Pulsing reset aborts device work; caller reissues. see R9 see R10 see R11
              flash_rst_n <= 1'b0;
              rst_cnt_r   <= CNT_W'(T_RESET_CYC);
              state_r     <= PFH_RESET;
            end
            else if (op_code == PFH_OP_READ)
            begin
              req_r   <= 1'b1;
              wr_r    <= 1'b0;
              state_r <= PFH_ACCESS; // see R2
            end
            else
            begin
              req_r   <= 1'b1;
              wr_r    <= 1'b1;
              state_r <= PFH_CMD;
            end
          end
        end
        PFH_CMD:
        begin
          // Each sequence is sent whole with no foreign cycle between. see R26
          if (cyc.done)
          begin
            if (step_r == seq_len(op_r) - 3'd1)
            begin
              if (op_r == PFH_OP_ID_ENTRY || op_r == PFH_OP_ID_EXIT)
                state_r <= PFH_RESP;
              else
              begin
                req_r   <= 1'b1;
                wr_r    <= 1'b0;
                state_r <= PFH_POLL;
              end
            end
            else
            begin
              step_r <= step_r + 3'd1;
              req_r  <= 1'b1;
            end
          end
        end
        PFH_ACCESS:
        begin
          if (cyc.done)
          begin
            rsp_rdata <= cyc.rdata; // see R1
            // The lockout flag is meaningful only in identification mode. see R25
            if (addr_r == (TOP_BOOT ? LOCK_DET_TOP : LOCK_DET_BOT))
              rsp_locked <= cyc.rdata[LOCK_BIT];
            state_r <= PFH_RESP;
          end
        end
        PFH_POLL:
        begin
          // Busy ends once two reads agree on the toggle bit; no commands go out
          // meanwhile since an erasing device would ignore them. see R15 see R18 see R23 see R27
          if (cyc.done)
          begin
            prev_r      <= cyc.rdata;
            have_prev_r <= 1'b1;
            poll_cnt_r  <= poll_cnt_r + 32'h00000001;
            if (have_prev_r && cyc.rdata[TOGGLE_BIT] == prev_r[TOGGLE_BIT])
            begin
              // Settled read returns true data, erased bytes as all ones. see R13 see R16 see R17 see R24
              rsp_rdata <= cyc.rdata;
              state_r   <= PFH_RESP;
            end
            else if (poll_cnt_r == 32'(POLL_LIMIT))
            begin
              rsp_timeout <= 1'b1;
              state_r     <= PFH_RESP;
            end
            else
              req_r <= 1'b1;
          end
        end
        PFH_RESET:
        begin
          rst_cnt_r <= rst_cnt_r - 8'h01;
          if (rst_cnt_r == 8'h01)
          begin
            flash_rst_n <= 1'b1;
            state_r     <= PFH_RESP;
          end
        end
        PFH_RESP:
        begin
          rsp_valid <= 1'b1;
          state_r   <= PFH_IDLE;
        end
        default:
        begin
          state_r <= PFH_IDLE;
        end
      endcase
    end
  end

  // Boot-block maps differ only in the lockout-detect address used above. see R21 see R22
  pfh_cycle u_cycle (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .cyc          (cyc.eng),
    .addr_pins    (address_pins),
    .data_pins_o  (data_pins_o),
    .data_pins_oe (data_pins_oe), // see R3
    .data_pins_i  (data_pins_i),
    .cs_n         (cs_n),
    .oe_n         (oe_n),
    .we_n         (we_n)
  );
endmodule : pfh_host

/* File: pfh_chk.sv */
/*
  Checker for the flash host pins: strobe shapes, holds and pulses.
  Assumes it is bound to pfh_host and sees only its ports.
*/
`timescale 1ns/10ps
module pfh_chk
  import pfh_pkg::*;
(
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  input wire logic                       rsp_valid,
  input wire logic                       boost_req,
  input wire logic [pfh_pkg::ADDR_W-1:0] address_pins,
  input wire logic [pfh_pkg::DATA_W-1:0] data_pins_o,
  input wire logic                       data_pins_oe,
  input wire logic                       cs_n,
  input wire logic                       oe_n,
  input wire logic                       we_n,
  input wire logic                       flash_rst_n,
  input wire logic                       boost_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_we_pulse;
    !we_n [*2] ##1 we_n;
  endsequence
  sequence s_read_open;
    !oe_n [*3];
  endsequence
  a_we_pulse_len: assert property ($fell(we_n) |-> s_we_pulse)
    else $error("Write pulse length wrong.");
  a_write_ctl: assert property (!we_n |-> !cs_n && oe_n && data_pins_oe)
    else $error("Write strobe without select or data.");
  a_cs_first: assert property ($fell(we_n) |-> $past(cs_n) == 1'b0)
    else $error("Select not low before write strobe.");
  a_addr_hold: assert property (!we_n |-> $stable(address_pins) && $stable(data_pins_o))
    else $error("Address or data moved in write pulse.");
  a_data_after: assert property ($rose(we_n) |-> !cs_n && data_pins_oe && $stable(data_pins_o))
    else $error("Data not held at strobe rise.");
  a_read_ctl: assert property (!oe_n |-> !cs_n && we_n && !data_pins_oe)
    else $error("Read gate opened in a wrong state.");
  a_read_open: assert property ($fell(oe_n) |-> s_read_open)
    else $error("Read gate too short.");
  a_rst_pulse: assert property ($fell(flash_rst_n) |-> !flash_rst_n [*8])
    else $error("Flash reset pulse too short.");
  a_boost_cause: assert property (boost_en |-> $past(boost_req) && $past(flash_rst_n))
    else $error("Boost without request.");
  a_rsp_once: assert property (rsp_valid |=> !rsp_valid)
    else $error("Response held too long.");
endmodule : pfh_chk
bind pfh_host pfh_chk i_chk (.*);

/* File: pfh_flash_model.sv */
/*
  Behavioural byte-wide flash: array, command decoder, lockout, busy timing.
  Assumes the bench resolves the shared data wire and returns it as data_in.
*/
`timescale 1ns/10ps
module pfh_flash_model
  import pfh_pkg::*;
#(
  parameter bit          TOP_BOOT = 1'b0,
  parameter int unsigned BUSY_NS  = 2000,
  parameter int unsigned ERASE_NS = 4000
)
(
  input  wire logic [pfh_pkg::ADDR_W-1:0] address_pins,
  input  wire logic [pfh_pkg::DATA_W-1:0] data_in,
  input  wire logic                       cs_n,
  input  wire logic                       oe_n,
  input  wire logic                       we_n,
  input  wire logic                       flash_rst_n,
  input  wire logic                       boost_en,
  input  wire logic                       stuck,
  output logic [pfh_pkg::DATA_W-1:0]      data_out,
  output logic                            data_oe
);
  logic [DATA_W-1:0] mem [ARRAY_DEPTH];
  logic [ADDR_W-1:0] lat_a;
  logic [ADDR_W-1:0] prog_a;
  logic [DATA_W-1:0] prog_d;
  realtime           busy_until = 0.0;
  int                step = 0;
  bit                locked;
  bit                id_mode;
  bit                tog;
  wire               wr_n = cs_n | we_n;
  initial foreach (mem[i]) mem[i] = ERASED_BYTE;
  assign data_oe = flash_rst_n && !cs_n && !oe_n && we_n;
  function automatic bit is_busy();
    return stuck || ($realtime < busy_until);
  endfunction : is_busy
  // The boot block sits at the bottom or the top of the array by variant.
  function automatic bit in_boot(input int unsigned a);
    return TOP_BOOT ? (a >= 32'h0001C000) : (a <= 32'h00003FFF);
  endfunction : in_boot
  // Commands only steer the decoder; stored bytes change only by program or erase.
  task automatic cmd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    if (step == 0 && a == CMD_ADDR_1 && d == CMD_DATA_AA) step = 1;
    else if (step == 1 && a == CMD_ADDR_2 && d == CMD_DATA_55) step = 2;
    else if (step == 2 && a == CMD_ADDR_1 && d == CMD_DATA_80) step = 3;
    else if (step == 2 && a == CMD_ADDR_1 && d == CMD_DATA_A0) step = 6;
    else if (step == 3 && a == CMD_ADDR_1 && d == CMD_DATA_AA) step = 4;
    else if (step == 4 && a == CMD_ADDR_2 && d == CMD_DATA_55) step = 5;
    else if (step == 6)
    begin
      if (!locked || boost_en || !in_boot(a)) mem[a] = mem[a] & d;
      prog_a = a;
      prog_d = d;
      busy_until = $realtime + BUSY_NS;
      step = 0;
    end
    else
    begin
      if (step == 2 && a == CMD_ADDR_1) id_mode = (d == CMD_DATA_ID);
      if (step == 5 && a == CMD_ADDR_1 && d == CMD_DATA_CHIP)
      begin
        foreach (mem[i]) if (!locked || !in_boot(i)) mem[i] = ERASED_BYTE;
        busy_until = $realtime + ERASE_NS;
      end
      if (step == 5 && a == CMD_ADDR_1 && d == CMD_DATA_LOCK)
      begin
        locked = 1'b1;
        busy_until = $realtime + BUSY_NS;
      end
      step = 0;
    end
  endtask : cmd
  always @(negedge wr_n) lat_a = address_pins;
  always @(posedge wr_n) if (flash_rst_n && oe_n && !is_busy()) cmd(lat_a, data_in);
  always @(negedge flash_rst_n)
  begin
    busy_until = 0.0;
    step = 0;
    id_mode = 1'b0;
  end
  always @(negedge oe_n)
  begin
    if (is_busy()) tog = !tog;
    if (id_mode) data_out = (address_pins == (TOP_BOOT ? LOCK_DET_TOP : LOCK_DET_BOT)) ? {7'h00, locked} : ERASED_BYTE;
    else data_out = mem[address_pins];
    if (is_busy()) data_out[TOGGLE_BIT] = tog;
    if (is_busy() && address_pins == prog_a) data_out[POLL_BIT] = !prog_d[POLL_BIT];
  end
endmodule : pfh_flash_model

/* File: parallel_flash_cmd_erase_port_tb_top.sv */
/*
  Testbench for pfh_host against the flash model: an operation table, then
  lockout override, busy timeout and reissue after flash reset.
  Assumes the package, design, checker and model are compiled first.
*/
`timescale 1ns/10ps
module parallel_flash_cmd_erase_port_tb_top;
  import pfh_pkg::*;
  typedef struct packed
  {
    pfh_op_t     op;
    logic [16:0] a;
    logic [7:0]  d;
    logic        k;
    logic [7:0]  e;
  } pfh_row_t;
  // Byte 04100 sits outside the boot block, so chip erase under lockout must clear it.
  localparam pfh_row_t ROWS [16] = '{
    '{PFH_OP_READ, 17'h04100, 8'h00, 1'b1, 8'hFF},
    '{PFH_OP_PROGRAM, 17'h04100, 8'h5A, 1'b1, 8'h5A},
    '{PFH_OP_READ, 17'h04100, 8'h00, 1'b1, 8'h5A},
    '{PFH_OP_READ, 17'h05555, 8'h00, 1'b1, 8'hFF},
    '{PFH_OP_PROGRAM, 17'h00010, 8'h3C, 1'b1, 8'h3C},
    '{PFH_OP_ID_ENTRY, 17'h00000, 8'h00, 1'b0, 8'h00},
    '{PFH_OP_READ, 17'h00002, 8'h00, 1'b1, 8'h00},
    '{PFH_OP_ID_EXIT, 17'h00000, 8'h00, 1'b0, 8'h00},
    '{PFH_OP_LOCKOUT, 17'h00000, 8'h00, 1'b1, 8'hFF},
    '{PFH_OP_ID_ENTRY, 17'h00000, 8'h00, 1'b0, 8'h00},
    '{PFH_OP_READ, 17'h00002, 8'h00, 1'b1, 8'h01},
    '{PFH_OP_ID_EXIT, 17'h00000, 8'h00, 1'b0, 8'h00},
    '{PFH_OP_CHIP_ERASE, 17'h04100, 8'h00, 1'b1, 8'hFF},
    '{PFH_OP_READ, 17'h00010, 8'h00, 1'b1, 8'h3C},
    '{PFH_OP_READ, 17'h04100, 8'h00, 1'b1, 8'hFF},
    '{PFH_OP_PROGRAM, 17'h00030, 8'h77, 1'b1, 8'hFF}
  };
  logic              clk_sys;
  logic              rst_n;
  logic              op_valid;
  logic              op_ready;
  pfh_op_t           op_code;
  logic [ADDR_W-1:0] op_addr;
  logic [DATA_W-1:0] op_wdata;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_rdata;
  logic              rsp_timeout;
  logic              rsp_locked;
  logic              boost_req;
  logic [ADDR_W-1:0] address_pins;
  logic [DATA_W-1:0] data_pins_o;
  logic              data_pins_oe;
  logic [DATA_W-1:0] data_pins_i;
  logic              cs_n;
  logic              oe_n;
  logic              we_n;
  logic              flash_rst_n;
  logic              boost_en;
  logic              stuck;
  logic              mdl_oe;
  logic [DATA_W-1:0] mdl_o;
  logic [DATA_W-1:0] bus_last;
  int                err_total;
  int                cmp_count;
  pfh_host #(.TOP_BOOT(1'b0), .POLL_LIMIT(40)) i_dut (.*);
  pfh_flash_model i_flash (.address_pins(address_pins), .data_in(data_pins_i), .cs_n(cs_n), .oe_n(oe_n),
    .we_n(we_n), .flash_rst_n(flash_rst_n), .boost_en(boost_en), .stuck(stuck), .data_out(mdl_o), .data_oe(mdl_oe));
  // A released wire shows the inverse of its last value so a stale byte never looks valid.
  assign data_pins_i = data_pins_oe ? data_pins_o : (mdl_oe ? mdl_o : ~bus_last);
  always @(posedge clk_sys) if (data_pins_oe || mdl_oe) bus_last <= data_pins_i;
  always @(posedge clk_sys) if (data_pins_oe && mdl_oe) chk("bus contention", 8'h00, 8'h01);
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic do_op(input pfh_op_t c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    chk("op ready", 8'h01, {7'h00, op_ready});
    op_code = c;
    op_addr = a;
    op_wdata = d;
    op_valid = 1'b1;
    @(posedge clk_sys);
    #1 op_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 5000)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (n >= 5000)
    begin
      err_total++;
      give_verdict();
    end
  endtask : do_op
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_code = PFH_OP_READ;
    op_addr = '0;
    op_wdata = '0;
    boost_req = 1'b0;
    stuck = 1'b0;
    bus_last = '0;
    err_total = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    @(posedge clk_sys);
    #1 chk("idle pins", 8'h3C, {2'b00, op_ready, cs_n, we_n, flash_rst_n, rsp_valid, data_pins_oe});
    foreach (ROWS[i])
    begin
      do_op(ROWS[i].op, ROWS[i].a, ROWS[i].d);
      if (ROWS[i].k) chk("read data", ROWS[i].e, rsp_rdata);
      chk("timeout flag", 8'h00, {7'h00, rsp_timeout});
    end
    chk("lock detect", 8'h01, {7'h00, rsp_locked});
    boost_req = 1'b1;
    do_op(PFH_OP_PROGRAM, 17'h00030, 8'h77);
    boost_req = 1'b0;
    do_op(PFH_OP_READ, 17'h00030, 8'h00);
    chk("boost override", 8'h77, rsp_rdata);
    stuck = 1'b1;
    do_op(PFH_OP_PROGRAM, 17'h04100, 8'h00);
    chk("busy timeout", 8'h01, {7'h00, rsp_timeout});
    stuck = 1'b0;
    do_op(PFH_OP_RESET, 17'h00000, 8'h00);
    do_op(PFH_OP_PROGRAM, 17'h04100, 8'h00);
    do_op(PFH_OP_READ, 17'h04100, 8'h00);
    chk("after reset", 8'h00, rsp_rdata);
    give_verdict();
  end
endmodule : parallel_flash_cmd_erase_port_tb_top
